// ==== rtl/ssm_ctrl.sv ====
// global control of the dual serial module: config, test, interrupt and
// queue control registers, queue ram, stop gating and freeze halting
// every access costs one wait cycle; registers live in the low half-word
// assumes an avalon-mm master with byte addresses; freeze comes from the system
// assumes requests stay low while reset is held
`timescale 1ns/1ps
`default_nettype none
module ssm_ctrl
	import ssm_pkg::*;
#(
	parameter int WORDS = RAM_WORDS,
	parameter int XLEN  = XFER_CYCLES
) (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        sys_rst_in,
	// avalon-mm slave
	input  wire logic [9:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// system
	input  wire logic        debug_freeze_in,   // asserted during background debug
	// status to the rest of the module
	output logic             module_clk_run_out, // low while the clock is gated off
	output logic             queue_busy_out,
	output logic [7:0]       queue_xfer_count_out
);
	typedef struct packed {
		logic              stop;     // low-power stop
		logic              fhs;      // freeze halt select
		logic              fss;      // spare freeze select
		logic [3:0]        arb;      // arbitration id
		logic [7:0]        test;     // factory test storage
		logic [7:0]        lvl;      // interrupt level reg
		logic [7:1]        vec;      // interrupt vector reg, bit 0 reads one
		logic              halt;     // queue halt request
		logic              run;      // queue enable
		logic              done;     // access answered this cycle
		logic [31:0]       rdata;    // read data
		logic [WORDS-1:0][15:0] ram; // queue ram
	} ssm_state_t;

	ssm_state_t s_r;   // registered state
	ssm_state_t s_nxt; // next state

	// registers reachable over the bus
	typedef enum logic [2:0] {
		SEL_NONE   = 3'b000, // unmapped: reads zero, writes dropped
		SEL_CONFIG = 3'b001, // module configuration
		SEL_TEST   = 3'b010, // factory test storage
		SEL_INT    = 3'b011, // level and vector pair
		SEL_QCTL3  = 3'b100, // queue control three
		SEL_RAM    = 3'b101  // queue ram window
	} ssm_sel_t;

	logic       eng_halted; // engine sitting at a boundary, halted
	logic       halt_cause; // halt request, or freeze with halt select
	logic       req;        // bus request pending
	logic       ram_hit;    // address falls in ram window
	logic [9:0] ram_ofs;    // byte offset into ram window
	logic [5:0] ram_idx;    // ram word index
	ssm_sel_t   sel;        // register named by the current request

	// address to register select; read and write paths share it so
	// they can never disagree on which register an offset names
	function automatic ssm_sel_t reg_decode(input logic [9:0] adr,
						input logic       in_ram);
		if (adr == OFS_CONFIG)
			reg_decode = SEL_CONFIG;
		else if (adr == OFS_TEST)
			reg_decode = SEL_TEST;
		else if (adr == OFS_INT)
			reg_decode = SEL_INT;
		else if (adr == OFS_QCTL3)
			reg_decode = SEL_QCTL3;
		else if (in_ram)
			reg_decode = SEL_RAM;
		else
			reg_decode = SEL_NONE; // R11
	endfunction

	// config register as software sees it; unused bits stay zero
	function automatic logic [15:0] cfg_word(input logic       stop,
						 input logic       fhs,
						 input logic       fss,
						 input logic [3:0] arb);
		cfg_word                = 16'h0000; // R11
		cfg_word[CFG_STOP_BIT]  = stop;
		cfg_word[CFG_FHS_BIT]   = fhs;
		cfg_word[CFG_FSS_BIT]   = fss;
		cfg_word[CFG_ARB_MSB:0] = arb;
	endfunction

	// level and vector pair; vector bit 0 has no storage and reads one
	function automatic logic [15:0] int_word(input logic [7:0] lvl,
						 input logic [7:1] vec);
		int_word = {lvl, vec, 1'b1}; // R12
	endfunction

	// queue control three as software sees it; ack is derived, not stored
	function automatic logic [15:0] q3_word(input logic halt,
						input logic run,
						input logic ack);
		q3_word              = 16'h0000; // R11
		q3_word[Q3_HALT_BIT] = halt;
		q3_word[Q3_RUN_BIT]  = run;
		q3_word[Q3_ACK_BIT]  = ack;
	endfunction

	// merge a 16-bit register with byte enables
	function automatic logic [15:0] be_merge(input logic [15:0] old_v,
						  input logic [15:0] new_v,
						  input logic [1:0]  be);
		be_merge = old_v;
		if (be[0])
			be_merge[7:0] = new_v[7:0];
		if (be[1])
			be_merge[15:8] = new_v[15:8];
	endfunction

	// address decode
	assign req     = avs_read_in | avs_write_in;
	assign ram_ofs = avs_address_in - OFS_RAM_BASE;
	assign ram_idx = ram_ofs[7:2];
	assign ram_hit = (avs_address_in >= OFS_RAM_BASE) && (ram_ofs[9:2] < 8'(WORDS));
	assign sel     = reg_decode(avs_address_in, ram_hit);

	// halt cause seen by the queue sequencer; freeze only counts with halt select
	assign halt_cause = s_r.halt | (s_r.fhs & debug_freeze_in); // R7 R8 R10

	// one wait cycle, then the access completes
	assign avs_waitrequest_out = req & ~s_r.done;

	// next state
	always_comb begin
		s_nxt      = s_r;
		// done marks the second cycle of an access, when wait drops
		s_nxt.done = req & ~s_r.done;
		// read data captured in the wait cycle, stands when wait drops
		if (avs_read_in && !s_r.done) begin
			s_nxt.rdata = 32'h0000_0000; // unmapped and unimplemented read zero R11
			if (sel == SEL_CONFIG)
				s_nxt.rdata[15:0] = cfg_word(s_r.stop, s_r.fhs, s_r.fss, s_r.arb); // R2
			else if (!s_r.stop) begin // other reads invalid while stopped R2 R3
				case (sel)
					// factory test storage, low byte only
					SEL_TEST:  s_nxt.rdata[7:0]  = s_r.test;
					// level above vector
					SEL_INT:   s_nxt.rdata[15:0] = int_word(s_r.lvl, s_r.vec); // R12
					// acknowledge only while halt is requested and reached
					SEL_QCTL3: s_nxt.rdata[15:0] = q3_word(s_r.halt, s_r.run,
									       s_r.halt & eng_halted); // R7
					// queue ram word
					SEL_RAM:   s_nxt.rdata[15:0] = s_r.ram[ram_idx];
					// unmapped: left at zero
					default:   s_nxt.rdata = 32'h0000_0000; // R11
				endcase
			end
		end
		// writes take effect at the edge where wait is low, stopped or not R4
		if (avs_write_in && s_r.done) begin
			if (sel == SEL_CONFIG) begin
				// high byte: stop and the two freeze selects
				if (avs_byteenable_in[1]) begin
					s_nxt.stop = avs_writedata_in[CFG_STOP_BIT]; // R5 R13
					s_nxt.fhs  = avs_writedata_in[CFG_FHS_BIT];  // R8
					s_nxt.fss  = avs_writedata_in[CFG_FSS_BIT];  // R9
				end
				// low byte: arbitration id; bits 12 to 4 have no storage R11
				if (avs_byteenable_in[0])
					s_nxt.arb = avs_writedata_in[CFG_ARB_MSB:0];
			end else if (sel == SEL_TEST) begin
				// factory test byte: plain storage
				if (avs_byteenable_in[0])
					s_nxt.test = avs_writedata_in[7:0];
			end else if (sel == SEL_INT) begin
				// level byte keeps its low six bits only
				if (avs_byteenable_in[1])
					s_nxt.lvl = avs_writedata_in[15:8] & LVL_MASK; // R11
				// vector byte: bit 0 has no storage
				if (avs_byteenable_in[0])
					s_nxt.vec = avs_writedata_in[7:1]; // bit 0 write ignored R12
			end else if (sel == SEL_QCTL3) begin
				// halt request and run; the acknowledge bit is read only
				if (avs_byteenable_in[0]) begin
					s_nxt.halt = avs_writedata_in[Q3_HALT_BIT]; // R7
					s_nxt.run  = avs_writedata_in[Q3_RUN_BIT];
				end
			end else if (sel == SEL_RAM)
				s_nxt.ram[ram_idx] = be_merge(s_r.ram[ram_idx],
							      avs_writedata_in[15:0],
							      avs_byteenable_in[1:0]);
		end
	end

	// state register; ram keeps its contents across reset and stop
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			s_r.stop  <= STOP_RST; // R5
			s_r.fhs   <= 1'b0;
			s_r.fss   <= 1'b0;
			s_r.arb   <= 4'h0;
			s_r.test  <= 8'h00;
			s_r.lvl   <= LVL_RST;
			s_r.vec   <= VEC_RST[7:1];
			s_r.halt  <= 1'b0;
			s_r.run   <= 1'b0;
			s_r.done  <= 1'b0;
			s_r.rdata <= 32'h0000_0000;
			s_r.ram   <= s_nxt.ram;
		end else
			s_r <= s_nxt;
	end

	// clock gate for the serial units
	assign module_clk_run_out = ~s_r.stop; // R1

	// queue sequencer; halts on request or freeze with halt select
	ssm_queue_engine #(
		.XFER_LEN (XLEN)
	) u_engine (
		.sys_clk_in     (sys_clk_in),
		.sys_rst_in     (sys_rst_in),
		.clk_run_in     (~s_r.stop),
		.enable_in      (s_r.run),
		.halt_in        (halt_cause), // R8 R10
		.halted_out     (eng_halted),
		.busy_out       (queue_busy_out),
		.xfer_count_out (queue_xfer_count_out)
	);

	assign avs_readdata_out = s_r.rdata;
endmodule
`default_nettype wire

// ==== rtl/ssm_pkg.sv ====
// constants shared by the dual serial module stop/freeze control block
// assumes a 32-bit avalon-mm slave with byte addresses and word-aligned registers
// How it works
// R1: stop bit gates module clock, enters stop
// R2: only config register reads valid while stopped
// R3: queue ram reads unsupported while stopped
// R4: writes to ram and registers work while stopped
// R5: stop bit writable, set by reset
// R6: host quiesces both units before stopping
// R7: halt request, wait acknowledge, then stop
// R8: freeze with halt select halts at boundary
// R9: spare freeze select is storage only
// R10: system asserts freeze during background debug
// R11: unimplemented bits ignore writes, read zero
// R12: level and vector registers share one word
// R13: clearing stop resumes with contents kept
package ssm_pkg;
	// register byte offsets
	localparam logic [9:0]  OFS_CONFIG    = 10'h000;
	localparam logic [9:0]  OFS_TEST      = 10'h004;
	localparam logic [9:0]  OFS_INT       = 10'h008;
	localparam logic [9:0]  OFS_QCTL3     = 10'h00c;
	localparam logic [9:0]  OFS_RAM_BASE  = 10'h100;
	// config register field positions
	localparam int          CFG_STOP_BIT  = 15;
	localparam int          CFG_FHS_BIT   = 14;
	localparam int          CFG_FSS_BIT   = 13;
	localparam int          CFG_ARB_MSB   = 3;
	// queue control three field positions
	localparam int          Q3_HALT_BIT   = 0;
	localparam int          Q3_RUN_BIT    = 1;
	localparam int          Q3_ACK_BIT    = 2;
	// interrupt word: level reg in [15:8], vector reg in [7:0]
	localparam int          INT_LVL_LSB   = 8;
	localparam logic [7:0]  LVL_MASK      = 8'h3f;
	// reset values
	localparam logic        STOP_RST      = 1'b1;
	localparam logic [7:0]  VEC_RST       = 8'h0f;
	localparam logic [7:0]  LVL_RST       = 8'h00;
	// queue ram size in 16-bit words and transfer length in clocks
	localparam int          RAM_WORDS     = 40;
	localparam int          XFER_CYCLES   = 17;
	// queue engine states
	typedef enum logic [1:0] {
		QE_IDLE   = 2'b00,
		QE_XFER   = 2'b01,
		QE_HALTED = 2'b10
	} ssm_qstate_t;
endpackage

// ==== rtl/ssm_queue_engine.sv ====
// queue transfer sequencer stand-in: runs fixed-length transfers back to back
// gates itself on clk_run_in rather than on enable; halts only at transfer boundaries
`timescale 1ns/1ps
`default_nettype none
module ssm_queue_engine
	import ssm_pkg::*;
#(
	parameter int XFER_LEN = XFER_CYCLES
) (
	// clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       sys_rst_in,
	// control
	input  wire logic       clk_run_in,   // module clock enabled (not stopped)
	input  wire logic       enable_in,    // queue enabled by software
	input  wire logic       halt_in,      // halt cause (request or freeze)
	// status
	output logic            halted_out,
	output logic            busy_out,
	output logic [7:0]      xfer_count_out
);
	typedef struct packed {
		ssm_qstate_t st;      // sequencer state
		logic [7:0]  cyc;     // cycles into current transfer
		logic [7:0]  done;    // completed transfers
	} ssm_qe_t;

	ssm_qe_t s_r;   // registered state
	ssm_qe_t s_nxt; // next state

	localparam logic [7:0] LAST_CYC = 8'(XFER_LEN - 1);

	// next state: frozen entirely while the module clock is gated
	always_comb begin
		s_nxt = s_r;
		if (clk_run_in) begin // R1 R13
			case (s_r.st)
				QE_IDLE: begin
					if (halt_in)
						s_nxt.st = QE_HALTED; // idle is a boundary
					else if (enable_in) begin
						s_nxt.st  = QE_XFER;
						s_nxt.cyc = 8'h00;
					end
				end
				QE_XFER: begin
					if (s_r.cyc == LAST_CYC) begin
						// transfer boundary
						s_nxt.done = s_r.done + 8'h01;
						s_nxt.cyc  = 8'h00;
						if (halt_in)
							s_nxt.st = QE_HALTED; // R7 R8
						else if (!enable_in)
							s_nxt.st = QE_IDLE;
					end else
						s_nxt.cyc = s_r.cyc + 8'h01;
				end
				QE_HALTED: begin
					if (!halt_in)
						s_nxt.st = QE_IDLE; // resume
				end
				default: s_nxt.st = QE_IDLE;
			endcase
		end
	end

	// state register
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			s_r <= '{st: QE_IDLE, cyc: 8'h00, done: 8'h00};
		else
			s_r <= s_nxt;
	end

	// outputs
	assign halted_out     = (s_r.st == QE_HALTED);
	assign busy_out       = (s_r.st == QE_XFER);
	assign xfer_count_out = s_r.done;
endmodule
`default_nettype wire

// ==== sim/ssm_ctrl_properties.sv ====
// concurrent checks on the ports of the stop/freeze control block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ssm_ctrl_properties
	import ssm_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk_in,
	input wire logic        sys_rst_in,
	// bus slave side
	input wire logic [9:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0]  avs_byteenable_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	// system and status
	input wire logic        debug_freeze_in,
	input wire logic        module_clk_run_out,
	input wire logic        queue_busy_out,
	input wire logic [7:0]  queue_xfer_count_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	// a read completing in this cycle
	wire logic rdone = avs_read_in & ~avs_waitrequest_out;
	a_reset_stops: assert property ($fell(sys_rst_in) |-> !module_clk_run_out)
		else $error("module clock running after reset");
	a_stop_read_zero: assert property (rdone && !module_clk_run_out
		&& avs_address_in != OFS_CONFIG |-> avs_readdata_out == 32'h0)
		else $error("nonzero read while stopped");
	a_config_view: assert property (rdone && avs_address_in == OFS_CONFIG
		|-> avs_readdata_out[CFG_STOP_BIT] == !module_clk_run_out && avs_readdata_out[12:4] == 9'h0)
		else $error("config read disagrees with stop state");
	a_upper_zero: assert property (rdone |-> avs_readdata_out[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_vector_lsb: assert property (rdone && module_clk_run_out && avs_address_in == OFS_INT
		|-> avs_readdata_out[0] && avs_readdata_out[15:14] == 2'h0)
		else $error("level/vector word bits wrong");
	a_ack_needs_halt: assert property (rdone && module_clk_run_out
		&& avs_address_in == OFS_QCTL3 && avs_readdata_out[Q3_ACK_BIT]
		|-> avs_readdata_out[Q3_HALT_BIT] && !queue_busy_out)
		else $error("halt acknowledge without halt");
	a_gated_still: assert property (!module_clk_run_out
		|=> $stable(queue_xfer_count_out) && $stable(queue_busy_out))
		else $error("queue moved while clock gated");
	a_count_step: assert property ($changed(queue_xfer_count_out)
		|-> queue_xfer_count_out == $past(queue_xfer_count_out) + 8'h1)
		else $error("transfer count jumped");
	a_wait_once: assert property ($rose(avs_read_in | avs_write_in)
		|-> avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("wait cycle count wrong");
endmodule
bind ssm_ctrl ssm_ctrl_properties i_props (.sys_clk_in, .sys_rst_in, .avs_address_in,
	.avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
	.avs_waitrequest_out, .debug_freeze_in, .module_clk_run_out, .queue_busy_out,
	.queue_xfer_count_out);
`default_nettype wire

// ==== sim/ssm_debug_host.sv ====
// system side model: raises freeze while the core sits in background debug
// assumes the bench says when debug mode is entered and left
`timescale 1ns/1ps
`default_nettype none
module ssm_debug_host (
	// clock
	input  wire logic sys_clk_in,
	// core state
	input  wire logic debug_mode_in,
	// freeze to the module
	output logic      debug_freeze_out
);
	// freeze follows debug mode one clock later
	always_ff @(posedge sys_clk_in) begin
		debug_freeze_out <= debug_mode_in;
	end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// bench for the stop/freeze control block: register sequences over the bus
// assumes a short transfer length so queue activity shows quickly
`timescale 1ns/1ps
`default_nettype none
module tb
	import ssm_pkg::*;
;
	logic        clk, rst, rd, wr, dbg, wq, run, busy, frz;
	logic [9:0]  adr;
	logic [31:0] wd, rdat, rv;
	logic [3:0]  be;
	logic [7:0]  cnt, c0;
	int          miscompares, comparisons;
	ssm_ctrl #(.XLEN(3)) i_dut (.sys_clk_in(clk), .sys_rst_in(rst), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wq), .debug_freeze_in(frz),
		.module_clk_run_out(run), .queue_busy_out(busy), .queue_xfer_count_out(cnt));
	ssm_debug_host i_host (.sys_clk_in(clk), .debug_mode_in(dbg), .debug_freeze_out(frz));
	// free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// one bus access, held until waitrequest is sampled low
	task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d);
		adr <= a;
		wd <= {16'h0, d};
		wr <= w;
		rd <= !w;
		@(posedge clk iff wq === 1'b0);
		rv = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input string n, input logic [9:0] a, input logic [31:0] e);
		acc(1'b0, a, 16'h0);
		chk(n, e, rv);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (4000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
	initial begin
		{rd, wr, dbg} = 3'h0;
		adr = 10'h0;
		wd = 32'h0;
		be = 4'h3;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc("cfg_rst", OFS_CONFIG, 32'h8000);
		chk("run_rst", 32'h0, {31'h0, run});
		acc(1'b1, OFS_TEST, 16'h005a);
		acc(1'b1, OFS_RAM_BASE + 10'h09c, 16'hbeef);
		rdc("test_stop", OFS_TEST, 32'h0);
		rdc("ram_stop", OFS_RAM_BASE + 10'h09c, 32'h0);
		acc(1'b1, OFS_CONFIG, 16'h7fff);
		rdc("cfg_bits", OFS_CONFIG, 32'h600f);
		rdc("test_kept", OFS_TEST, 32'h5a);
		rdc("ram_kept", OFS_RAM_BASE + 10'h09c, 32'hbeef);
		rdc("int_rst", OFS_INT, 32'h0f);
		acc(1'b1, OFS_INT, 16'hffff);
		rdc("int_wr", OFS_INT, 32'h3fff);
		rdc("unmapped", 10'h010, 32'h0);
		acc(1'b1, OFS_QCTL3, 16'h0002);
		repeat (20) @(posedge clk);
		chk("q_runs", 32'h1, {31'h0, cnt != 8'h0});
		chk("q_busy", 32'h1, {31'h0, busy});
		dbg <= 1'b1;
		repeat (10) @(posedge clk);
		c0 = cnt;
		repeat (20) @(posedge clk);
		chk("frz_cnt", {24'h0, c0}, {24'h0, cnt});
		chk("frz_busy", 32'h0, {31'h0, busy});
		dbg <= 1'b0;
		acc(1'b1, OFS_CONFIG, 16'h2000);
		dbg <= 1'b1;
		repeat (20) @(posedge clk);
		chk("spare", 32'h1, {31'h0, cnt != c0});
		dbg <= 1'b0;
		acc(1'b1, OFS_QCTL3, 16'h0003);
		rv = 32'h0;
		for (int i = 0; i < 20 && rv[Q3_ACK_BIT] !== 1'b1; i++)
			acc(1'b0, OFS_QCTL3, 16'h0);
		chk("ack", 32'h7, rv);
		c0 = cnt;
		acc(1'b1, OFS_CONFIG, 16'h8000);
		chk("run_stop", 32'h0, {31'h0, run});
		repeat (20) @(posedge clk);
		chk("stop_cnt", {24'h0, c0}, {24'h0, cnt});
		acc(1'b1, OFS_QCTL3, 16'h0002);
		repeat (10) @(posedge clk);
		chk("stop_frozen", {24'h0, c0}, {24'h0, cnt});
		rdc("q3_stop", OFS_QCTL3, 32'h0);
		acc(1'b1, OFS_CONFIG, 16'h0000);
		rdc("q3_kept", OFS_QCTL3, 32'h2);
		repeat (10) @(posedge clk);
		chk("resume", 32'h1, {31'h0, cnt != c0});
		end_of_test();
	end
endmodule
`default_nettype wire
